//--- logic/psms_pkg.sv
// Package: constants, encodings and carriers for the partition space selector
//
// How it works
// - Without realm support one space bit: 0 secure, 1 non-secure.
// - Realm support: two-bit space, 00 secure, 01 ns, 10 root, 11 realm.
// - A realm-capable build with partitioning distinguishes all four spaces.
// - Every non-secure state stream access carries the non-secure space, always.
// - Secure override capability 0 keeps all secure stream accesses secure.
// - Secure override capability 1: each control's bit picks secure or ns.
// - Realm override capability 1: global or entry bit forces ns space.
// - Overrides change only the space; partition and group pass as is.
// - Descriptor and partition-map fetches inherit the entry's space.
// - Streamless: device or target space; device space if device gives ids.
// - Without two-bit space, streamless root maps to 0 and realm maps to 1.
// - Context support and its id width are reported for identification.
// - Secure, non-secure and root state accesses (streamless: target space) carry context id zero.
// - Realm accesses take context id from global register or entry, or from the device if streamless.
// - A build without realm interface tags all with context id zero.
// - Contexts supported and realm leaf bit 63 set: translation fault.
// - Descriptor non-secure bit set makes the alternative bit read as zero.
// - Context support absent means the alternative bit is ignored, no fault.
`default_nettype none
package psms_pkg;

  // Field widths fixed at build
  localparam int PART_W = 16;
  localparam int MON_W  = 8;
  localparam int CTX_W  = 16;

  // Two-bit space encodings
  localparam logic [1:0] SP_SECURE = 2'h0;
  localparam logic [1:0] SP_NONSEC = 2'h1;
  localparam logic [1:0] SP_ROOT   = 2'h2;
  localparam logic [1:0] SP_REALM  = 2'h3;

  // One-bit space encodings
  localparam logic ONE_SECURE = 1'b0;
  localparam logic ONE_NONSEC = 1'b1;

  // Descriptor bit positions
  localparam int DESC_ALT_BIT = 63;
  localparam int DESC_NS_BIT  = 5;

  // Reset values
  localparam logic [CTX_W-1:0]  CTX_ZERO  = 16'h0000;
  localparam logic [PART_W-1:0] PART_ZERO = 16'h0000;
  localparam logic [MON_W-1:0]  MON_ZERO  = 8'h00;

  // Security state of the access
  typedef enum logic [1:0] {
    PSMS_ST_SECURE = 2'h0,
    PSMS_ST_NONSEC = 2'h1,
    PSMS_ST_ROOT   = 2'h2,
    PSMS_ST_REALM  = 2'h3
  } psms_state_t;

  // Kind of access, chooses override source
  typedef enum logic [2:0] {
    PSMS_K_CLIENT = 3'h0,  // Stream client, stream entry governs
    PSMS_K_GLOBAL = 3'h1,  // Queue or table access, global cfg governs
    PSMS_K_BYPASS = 3'h2,  // Global bypass, bypass cfg governs secure, stream entry governs realm
    PSMS_K_CTXD   = 3'h3,  // Context descriptor fetch
    PSMS_K_VMAP   = 3'h4,  // Partition map fetch
    PSMS_K_NOSID  = 3'h5   // Streamless client or its walk
  } psms_kind_t;

  // Incoming request
  typedef struct packed {
    psms_state_t            state;
    psms_kind_t             kind;
    logic [1:0]             target_pa;    // Target physical space
    logic                   ste_ns;       // Stream entry override bit
    logic [CTX_W-1:0]       ste_ctx;      // Stream entry context id
    logic [PART_W-1:0]      part;
    logic [MON_W-1:0]       mon;
    logic                   dev_ids;      // Ids supplied by device
    logic [1:0]             dev_space;    // Device supplied space
    logic [CTX_W-1:0]       dev_ctx;      // Device supplied context id
  } psms_req_t;

  // Outgoing attributes
  typedef struct packed {
    logic [1:0]        two_bit_space_attr;
    logic              one_bit_space_attr;
    logic [PART_W-1:0] partition_id;
    logic [MON_W-1:0]  monitor_group;
    logic [CTX_W-1:0]  encryption_context_id;
  } psms_attr_t;

  // Software controls
  typedef struct packed {
    logic             s_override_cap;   // Secure capability bit
    logic             r_override_cap;   // Realm capability bit
    logic             s_global_ns;
    logic             s_bypass_ns;
    logic             r_global_ns;
    logic [CTX_W-1:0] realm_global_context_id;
  } psms_cfg_t;

endpackage
`default_nettype wire

//--- logic/psms_space_sel.sv
// Combinational partition space chooser
`default_nettype none
module psms_space_sel #(
  parameter bit HAS_TWO_BIT = 1'b1,
  parameter bit DEV_SPACE   = 1'b0
) (
  // Request and controls
  input  wire psms_pkg::psms_req_t req,
  input  wire psms_pkg::psms_cfg_t cfg,
  // Chosen space
  output logic [1:0]               space2,
  output logic                     space1
);

  // Override bit that governs this access
  wire sec_ov  = (req.kind == psms_pkg::PSMS_K_GLOBAL) ? cfg.s_global_ns :
                 (req.kind == psms_pkg::PSMS_K_BYPASS) ? cfg.s_bypass_ns :
                 req.ste_ns;                  // Ctx/map inherit entry
  wire rlm_ov  = (req.kind == psms_pkg::PSMS_K_GLOBAL) ? cfg.r_global_ns :
                 req.ste_ns;
  wire sec_ns  = cfg.s_override_cap & sec_ov;
  wire rlm_ns  = cfg.r_override_cap & rlm_ov;
  wire nosid   = req.kind == psms_pkg::PSMS_K_NOSID;
  wire use_dev = DEV_SPACE | req.dev_ids;

  // Stream path space selection
  wire [1:0] str_sp =
    (req.state == psms_pkg::PSMS_ST_NONSEC) ? psms_pkg::SP_NONSEC :
    (req.state == psms_pkg::PSMS_ST_SECURE) ?
      (sec_ns ? psms_pkg::SP_NONSEC : psms_pkg::SP_SECURE) :
    (req.state == psms_pkg::PSMS_ST_REALM) ?
      (rlm_ns ? psms_pkg::SP_NONSEC : psms_pkg::SP_REALM) :
    psms_pkg::SP_ROOT;

  // Streamless: device value or target space
  wire [1:0] nos_sp = use_dev ? req.dev_space : req.target_pa;

  assign space2 = nosid ? nos_sp : str_sp;
  // Fold to one bit: root to 0, realm to 1
  assign space1 = (space2 == psms_pkg::SP_SECURE ||
                   space2 == psms_pkg::SP_ROOT) ?
                  psms_pkg::ONE_SECURE : psms_pkg::ONE_NONSEC;

endmodule // psms_space_sel
`default_nettype wire

//--- logic/psms_alt_check.sv
// Descriptor alternative-context bit fault check
`default_nettype none
module psms_alt_check (
  // Descriptor and walk context
  input  wire logic [63:0] desc,
  input  wire logic        leaf,        // Page or block descriptor
  input  wire logic        realm_walk,
  input  wire logic        ctx_support,
  // Result
  output logic             fault
);

  // Non-secure descriptors read the bit as zero
  wire alt_eff = desc[psms_pkg::DESC_ALT_BIT]
               & ~desc[psms_pkg::DESC_NS_BIT];
  // Fault only when contexts supported on a realm leaf
  assign fault = ctx_support & realm_walk & leaf & alt_eff;

endmodule // psms_alt_check
`default_nettype wire

//--- logic/psms_top.sv
// Top: registered attribute selection and descriptor fault reporting
`default_nettype none
module psms_top #(
  parameter bit          HAS_REALM_IF = 1'b1,
  parameter bit          HAS_TWO_BIT  = 1'b1,
  parameter bit          CTX_SUPPORT  = 1'b1,
  parameter bit          DEV_SPACE    = 1'b0,
  parameter logic [4:0]  CTX_WIDTH    = 5'h10
) (
  // Clock, reset, enable
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Request side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire psms_pkg::psms_req_t  req,
  // Software controls
  input  wire psms_pkg::psms_cfg_t  cfg,
  // Outgoing side
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output psms_pkg::psms_attr_t      out_attr,
  // Descriptor check
  input  wire logic                 desc_valid,
  input  wire logic [63:0]          desc,
  input  wire logic                 desc_leaf,
  input  wire logic                 desc_realm,
  output logic                      desc_fault_r,
  // Identification
  output logic                      ctx_supported,
  output logic [4:0]                ctx_width
);

  ////////////////////////////////////////////////////////////////////
  // Space selection
  logic [1:0] sp2;
  logic       sp1;
  psms_space_sel #(
    .HAS_TWO_BIT (HAS_TWO_BIT),
    .DEV_SPACE   (DEV_SPACE)
  ) u_sel (
    .req    (req),
    .cfg    (cfg),
    .space2 (sp2),
    .space1 (sp1)
  );

  // Context id by security state, or by target space if streamless
  wire realm_tgt = (req.kind == psms_pkg::PSMS_K_NOSID) ?
                   (req.target_pa == psms_pkg::SP_REALM) :
                   (req.state == psms_pkg::PSMS_ST_REALM);
  wire [psms_pkg::CTX_W-1:0] ctx_src =
    (req.kind == psms_pkg::PSMS_K_NOSID) ? req.dev_ctx :
    (req.kind == psms_pkg::PSMS_K_GLOBAL) ?
      cfg.realm_global_context_id : req.ste_ctx;
  wire [psms_pkg::CTX_W-1:0] ctx_sel =
    (HAS_REALM_IF && CTX_SUPPORT && realm_tgt) ? ctx_src :
    psms_pkg::CTX_ZERO;

  // Next attribute word
  psms_pkg::psms_attr_t attr_nxt;
  assign attr_nxt.two_bit_space_attr    = HAS_TWO_BIT ? sp2 :
                                          psms_pkg::SP_SECURE;
  assign attr_nxt.one_bit_space_attr    = sp1;
  assign attr_nxt.partition_id          = req.part;
  assign attr_nxt.monitor_group         = req.mon;
  assign attr_nxt.encryption_context_id = ctx_sel;

  ////////////////////////////////////////////////////////////////////
  // Output stage: one slot, held while stalled
  wire load = req_valid && (!out_valid || out_ready);
  wire fault_c;
  psms_alt_check u_chk (
    .desc        (desc),
    .leaf        (desc_leaf),
    .realm_walk  (desc_realm),
    .ctx_support (CTX_SUPPORT && HAS_REALM_IF),  // Reported support
    .fault       (fault_c)
  );

  // Request slot held until taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_attr  <= '0;
    end else if (ce) begin
      if (load) begin
        out_valid <= 1'b1;
        out_attr  <= attr_nxt;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  // Ready mirrors slot state, registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else if (ce) begin
      req_ready <= !(out_valid && !out_ready && !load) && !load ||
                   (load && out_ready);
    end
  end

  // Descriptor fault pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc_fault_r <= 1'b0;
    end else if (ce) begin
      desc_fault_r <= desc_valid && fault_c;
    end
  end

  // Identification
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctx_supported <= 1'b0;
      ctx_width     <= 5'h00;
    end else if (ce) begin
      ctx_supported <= CTX_SUPPORT & HAS_REALM_IF;
      ctx_width     <= (CTX_SUPPORT & HAS_REALM_IF) ? CTX_WIDTH : 5'h00;
    end
  end

endmodule // psms_top
`default_nettype wire

//--- dv/psms_top_sva.sv
// Checker of the partition space selector top ports
`default_nettype none
module psms_top_sva (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                ce,
  // Request and outgoing
  input wire logic                req_valid,
  input wire psms_pkg::psms_req_t req,
  input wire psms_pkg::psms_cfg_t cfg,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire psms_pkg::psms_attr_t out_attr,
  // Descriptor check
  input wire logic                desc_valid,
  input wire logic [63:0]         desc,
  input wire logic                desc_leaf,
  input wire logic                desc_realm,
  input wire logic                desc_fault_r,
  input wire logic                ctx_supported
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // Take condition, same as the slot load
  wire tk   = ce && req_valid && (!out_valid || out_ready);
  // Streamless requests follow device or target space, not the state
  wire sid  = req.kind != psms_pkg::PSMS_K_NOSID;
  wire tk_n = tk && sid && req.state == psms_pkg::PSMS_ST_NONSEC;
  wire tk_s = tk && sid && req.state == psms_pkg::PSMS_ST_SECURE;
  wire tk_r = tk && sid && req.state == psms_pkg::PSMS_ST_REALM;
  // Realm leaf, alternative bit set, ns bit clear, support reported
  wire alt  = desc_valid && ce && desc_leaf && desc_realm && desc[63]
              && !desc[5] && ctx_supported;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Space, context, partition/group pass-through and stall hold relations, one cycle behind
  AST_NS_STATE: assert property (
    tk_n |=> out_attr.two_bit_space_attr == 2'h1
    && out_attr.one_bit_space_attr)
    else $error("non-secure state lost ns space");
  AST_S_NOCAP: assert property (
    tk_s && !cfg.s_override_cap
    |=> out_attr.two_bit_space_attr == 2'h0)
    else $error("secure access left secure space");
  AST_S_CAP: assert property (
    tk_s && cfg.s_override_cap && req.kind == psms_pkg::PSMS_K_CLIENT
    |=> out_attr.two_bit_space_attr == {1'b0, $past(req.ste_ns)})
    else $error("secure override bit not followed");
  AST_R_GLOBAL: assert property (
    tk_r && req.kind == psms_pkg::PSMS_K_GLOBAL && cfg.r_override_cap
    && cfg.r_global_ns |=> out_attr.two_bit_space_attr == 2'h1)
    else $error("realm global override ignored");
  AST_IDS_PASS: assert property (
    tk |=> out_valid
    && out_attr.partition_id == $past(req.part)
    && out_attr.monitor_group == $past(req.mon))
    else $error("partition or group value altered");
  AST_CTX_ZERO: assert property (
    tk && sid && req.state != psms_pkg::PSMS_ST_REALM
    |=> out_attr.encryption_context_id == 16'h0000)
    else $error("non-realm access with nonzero context");
  AST_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_attr))
    else $error("attributes moved while stalled");
  ////////////////////////////////////////////////////////////////////////////
  // Descriptor fault pulse
  AST_ALT_FAULT: assert property (
    alt |=> desc_fault_r ##1 (!desc_fault_r || $past(alt)))
    else $error("alternative bit fault missing");
  AST_ALT_NS: assert property (
    desc_valid && ce && desc[5] |=> !desc_fault_r)
    else $error("fault raised with ns bit set");
  AST_NO_CTX: assert property (
    desc_valid && ce && !ctx_supported |=> !desc_fault_r)
    else $error("fault raised without context support");
endmodule // psms_top_sva
bind psms_top psms_top_sva u_sva (.mclk, .rst, .ce, .req_valid, .req, .cfg,
  .out_valid, .out_ready, .out_attr, .desc_valid, .desc, .desc_leaf,
  .desc_realm, .desc_fault_r, .ctx_supported);
`default_nettype wire

//--- dv/psms_sink.sv
// Downstream interconnect model that stalls each attribute word for two cycles while stall is high
`default_nettype none
module psms_sink (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Handshake
  input  wire logic stall,
  input  wire logic out_valid,
  output logic      out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  ////////////////////////////////////////////////////////////////////////////
  // Ready late on purpose, so the hold of a stalled word is exercised
  assign out_ready = !stall || wait_r == 2'h2;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wait_r <= 2'h0;
    else wait_r <= (out_valid && !out_ready) ? wait_r + 2'h1 : 2'h0;
  end
endmodule // psms_sink
`default_nettype wire

//--- dv/tb.sv
// Bench for the partition space selector
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus
  logic                 mclk       = 1'b0;
  logic                 rst        = 1'b1;
  logic                 ce         = 1'b1;
  logic                 req_valid  = 1'b0;
  logic                 stall      = 1'b0;
  logic                 desc_valid = 1'b0;
  logic                 desc_leaf  = 1'b0;
  logic                 desc_realm = 1'b0;
  logic [63:0]          desc       = 64'h0000_0000_0000_0000;
  psms_pkg::psms_req_t  req        = '0;
  psms_pkg::psms_cfg_t  cfg        = '0;
  // Full build outputs
  logic                 out_ready;
  logic                 out_valid;
  logic                 req_ready;
  logic                 desc_fault_r;
  logic                 ctx_supported;
  logic [4:0]           ctx_width;
  psms_pkg::psms_attr_t out_attr;
  // Build without realm interface, same stimulus
  logic                 nr_out_valid;
  logic                 nr_req_ready;
  logic                 nr_desc_fault_r;
  logic                 nr_ctx_supported;
  logic [4:0]           nr_ctx_width;
  psms_pkg::psms_attr_t nr_out_attr;
  int                   fails      = 0;
  int                   checks     = 0;
  always #25 mclk = ~mclk;
  psms_top u_dut (.mclk, .rst, .ce, .req_valid, .req_ready, .req, .cfg,
    .out_valid, .out_ready, .out_attr, .desc_valid, .desc, .desc_leaf,
    .desc_realm, .desc_fault_r, .ctx_supported, .ctx_width);
  // Loads in lockstep with u_dut, so the shared ready suits both
  psms_top #(.HAS_REALM_IF(1'b0)) u_dut_nr (.mclk, .rst, .ce, .req_valid,
    .req_ready(nr_req_ready), .req, .cfg, .out_valid(nr_out_valid),
    .out_ready, .out_attr(nr_out_attr), .desc_valid, .desc, .desc_leaf,
    .desc_realm, .desc_fault_r(nr_desc_fault_r),
    .ctx_supported(nr_ctx_supported), .ctx_width(nr_ctx_width));
  psms_sink u_sink (.mclk, .rst, .stall, .out_valid, .out_ready);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One request, then wait for the word to be taken downstream
  task automatic xfer(input logic [1:0] st, input logic [2:0] k,
      input logic [1:0] tg, input logic ns, input logic [1:0] e2,
      input logic [15:0] ectx);
    int n;
    @(posedge mclk);
    req.state <= psms_pkg::psms_state_t'(st);
    req.kind <= psms_pkg::psms_kind_t'(k);
    req.target_pa <= tg;
    req.ste_ns <= ns;
    req.ste_ctx <= 16'h00a5;
    req.part <= 16'h1234;
    req.mon <= 8'h56;
    req.dev_ctx <= 16'h0c3c;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    for (n = 0; n < 20 && !(out_valid === 1'b1 && out_ready === 1'b1); n++)
      @(negedge mclk);
    if (n == 20) begin
      fails++;
      finish_test();
    end
    chk(out_attr.two_bit_space_attr, e2);
    chk(out_attr.one_bit_space_attr, e2[0]);
    chk(out_attr.encryption_context_id, ectx);
    chk(out_attr.partition_id, 16'h1234);
    chk(out_attr.monitor_group, 8'h56);
    chk(nr_out_valid, 1'b1);
    chk(nr_out_attr.two_bit_space_attr, e2);
    chk(nr_out_attr.encryption_context_id, 16'h0000);
  endtask
  task automatic dchk(input logic alt, input logic ns, input logic rl,
      input logic exp);
    @(posedge mclk);
    desc <= {alt, 57'h0, ns, 5'h03};
    {desc_valid, desc_leaf, desc_realm} <= {2'b11, rl};
    @(posedge mclk);
    desc_valid <= 1'b0;
    @(negedge mclk);
    chk(desc_fault_r, exp);
    chk(nr_desc_fault_r, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Identification loads at the first edge after release
    @(posedge mclk);
    @(negedge mclk);
    chk({ctx_supported, ctx_width}, 6'h30);
    chk({nr_ctx_supported, nr_ctx_width}, 6'h00);
    chk(req_ready, 1'b1);
    // Low enable freezes the slot: an offered request is not taken
    @(posedge mclk);
    ce <= 1'b0;
    req_valid <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(out_valid, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    req_valid <= 1'b0;
    xfer(2'h1, 3'h0, 2'h1, 1'b0, 2'h1, 16'h0);
    xfer(2'h0, 3'h0, 2'h0, 1'b1, 2'h0, 16'h0);
    @(posedge mclk);
    cfg.s_override_cap <= 1'b1;
    cfg.s_global_ns <= 1'b1;
    stall <= 1'b1;
    xfer(2'h0, 3'h0, 2'h0, 1'b1, 2'h1, 16'h0);
    xfer(2'h0, 3'h1, 2'h0, 1'b0, 2'h1, 16'h0);
    xfer(2'h0, 3'h2, 2'h0, 1'b1, 2'h0, 16'h0);
    xfer(2'h0, 3'h3, 2'h0, 1'b1, 2'h1, 16'h0);
    xfer(2'h0, 3'h4, 2'h0, 1'b0, 2'h0, 16'h0);
    @(posedge mclk);
    cfg.r_override_cap <= 1'b1;
    cfg.r_global_ns <= 1'b1;
    cfg.realm_global_context_id <= 16'h7e81;
    xfer(2'h3, 3'h1, 2'h3, 1'b0, 2'h1, 16'h7e81);
    xfer(2'h3, 3'h0, 2'h3, 1'b0, 2'h3, 16'h00a5);
    @(posedge mclk);
    stall <= 1'b0;
    xfer(2'h2, 3'h0, 2'h2, 1'b0, 2'h2, 16'h0);
    xfer(2'h3, 3'h5, 2'h3, 1'b0, 2'h3, 16'h0c3c);
    @(posedge mclk);
    req.dev_ids <= 1'b1;
    xfer(2'h3, 3'h5, 2'h3, 1'b0, 2'h0, 16'h0c3c);
    dchk(1'b1, 1'b0, 1'b1, 1'b1);
    dchk(1'b1, 1'b1, 1'b1, 1'b0);
    dchk(1'b1, 1'b0, 1'b0, 1'b0);
    dchk(1'b0, 1'b0, 1'b1, 1'b0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
